// ---- logic/srps_sequencer.sv ----
// Power-on, reset-release and lock sequencer of the serial-video receiver.
// Assumes all inputs are synchronous to clock and that the host keeps the
// power-on and release ordering that the device relies on.
`timescale 1ns/1ns
`include "srps_map.svh"
module srps_sequencer import srps_pkg::*; #(
  parameter int unsigned LOCK_CYCLES = `SRPS_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Power-down pin, low means power down
  input wire logic chip_power_down_in,
  // Soft reset releases from the host, high means released
  input wire srps_soft_release_type soft_release,
  // Host register access request and grant
  input wire logic access_req,
  output logic access_grant_out,
  // Main link status from the receiver front end
  input wire srps_link_status_type link_status,
  // Block resets, high holds the block in reset
  output logic link_rx_rst_out,
  output logic pll_rst_out,
  output logic mipi_rst_out,
  // Status pins
  output logic hot_plug_detect_out,
  output logic link_lock_status_out,
  // MIPI output state
  output srps_mipi_state_type mipi_state_out,
  output logic mipi_first_done_out
);

  srps_lock_state_type lock_state_reg;
  srps_lock_state_type lock_state_next;
  srps_mipi_state_type mipi_state_next;
  logic lock_timer_done;
  logic link_rx_rst_next;
  logic pll_rst_next;
  logic mipi_rst_next;
  logic hpd_next;
  logic lock_n_next;
  logic first_done_next;
  logic grant_next;

  // A low power-down input acts as a synchronous reset of every state bit.
  wire powered = chip_power_down_in;
  wire rx_active = powered & soft_release.link_rx;
  wire pll_active = powered & soft_release.pll;
  // MIPI leaves reset only once both upstream blocks run, so a host that
  // releases out of order cannot start MIPI on a dead PLL.
  wire mipi_active = rx_active & pll_active & soft_release.mipi;
  wire training_seen = link_status.training & ~link_status.signal_lost;
  wire is_locked = (lock_state_next == LOCK_LOCKED);
  wire video_ok = is_locked & link_status.video;

  // Each block is held in reset until explicitly released.
  assign link_rx_rst_next = ~rx_active;
  assign pll_rst_next = ~pll_active;
  assign mipi_rst_next = ~mipi_active;

  // Hot-plug falls one cycle after the receiver release, far inside 10 us.
  assign hpd_next = ~rx_active;

  srps_timer #(
    .LIMIT(`SRPS_TIMER_W'(LOCK_CYCLES))
  ) u_lock_timer (
    .clock(clock),
    .rstn(rstn),
    .run(rx_active && (lock_state_reg == LOCK_TRAIN) && training_seen),
    .done(lock_timer_done)
  );

  // The receiver retrains by itself after noise; no host step is needed.
  always_comb begin
    lock_state_next = lock_state_reg;
    case (lock_state_reg)
      LOCK_IDLE: begin
        if (training_seen) begin
          lock_state_next = LOCK_TRAIN;
        end
      end
      LOCK_TRAIN: begin
        if (!training_seen) begin
          lock_state_next = LOCK_IDLE;
        end else if (lock_timer_done) begin
          lock_state_next = LOCK_LOCKED;
        end
      end
      LOCK_LOCKED: begin
        if (link_status.signal_lost) begin
          lock_state_next = LOCK_IDLE;
        end
      end
      default: begin
        lock_state_next = LOCK_IDLE;
      end
    endcase
    if (!rx_active) begin
      lock_state_next = LOCK_IDLE;
    end
  end

  assign lock_n_next = ~is_locked;

  // First start after power-on waits for blanking; later restarts do not,
  // since a frame boundary is already known then.
  always_comb begin
    mipi_state_next = mipi_state_out;
    case (mipi_state_out)
      MIPI_RESET: begin
        mipi_state_next = MIPI_LP11;
      end
      MIPI_LP11: begin
        if (video_ok && (mipi_first_done_out || link_status.vblank)) begin
          mipi_state_next = MIPI_HS;
        end
      end
      MIPI_HS: begin
        if (!is_locked) begin
          mipi_state_next = MIPI_LP11;
        end else if (!link_status.video) begin
          mipi_state_next = MIPI_LP11;
        end
      end
      default: begin
        mipi_state_next = MIPI_RESET;
      end
    endcase
    if (!mipi_active) begin
      mipi_state_next = MIPI_RESET;
    end
  end

  assign first_done_next = powered & (mipi_first_done_out | (mipi_state_next == MIPI_HS));
  assign grant_next = powered & access_req;

  // Each register has its own short process so that the reset value and
  // the next-state source of every output can be read side by side.
  // The asynchronous reset only covers the first moments of supply ramp;
  // the power-down pin then keeps the same values through the next-state
  // logic, so both reset paths agree on every output.

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_state_reg <= LOCK_IDLE;
    end else begin
      lock_state_reg <= lock_state_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mipi_state_out <= MIPI_RESET;
    end else begin
      mipi_state_out <= mipi_state_next;
    end
  end

  // The first-start flag survives lock loss but not power-down, so only a
  // fresh power-on makes MIPI wait for blanking again.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mipi_first_done_out <= 1'b0;
    end else begin
      mipi_first_done_out <= first_done_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_rx_rst_out <= `SRPS_BLOCK_RST_RESET_VAL;
    end else begin
      link_rx_rst_out <= link_rx_rst_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pll_rst_out <= `SRPS_BLOCK_RST_RESET_VAL;
    end else begin
      pll_rst_out <= pll_rst_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mipi_rst_out <= `SRPS_BLOCK_RST_RESET_VAL;
    end else begin
      mipi_rst_out <= mipi_rst_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hot_plug_detect_out <= `SRPS_HPD_RESET_VAL;
    end else begin
      hot_plug_detect_out <= hpd_next;
    end
  end

  // Lock status is active low, so reset shows the unlocked level.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_lock_status_out <= `SRPS_LOCK_RESET_VAL;
    end else begin
      link_lock_status_out <= lock_n_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      access_grant_out <= 1'b0;
    end else begin
      access_grant_out <= grant_next;
    end
  end

endmodule : srps_sequencer

// ---- logic/srps_map.svh ----
// Constants for the receiver power-on, reset-release and lock sequencer.
// Assumes a single 250 MHz clock and that every input is already synchronous.
// Function
// - MIPI, PLL and link receiver start in reset.
// - Hot-plug low within 10 us of release.
// - Lock status low within 980 us of training.
// - First video out within 50 us plus frame.
// - First output waits for vertical blanking.
// - Receiver locks and relocks without host action.
// - Lock lost puts MIPI in LP11 within 98 us.
// - After relock video resumes within 50 us.
`ifndef SRPS_MAP_SVH
`define SRPS_MAP_SVH

`define SRPS_CLK_MHZ 250
`define SRPS_LOCK_MAX_US 980
`define SRPS_LOCK_CYCLES (`SRPS_LOCK_MAX_US * `SRPS_CLK_MHZ)
`define SRPS_TIMER_W 18
`define SRPS_HPD_RESET_VAL 1'b1
`define SRPS_LOCK_RESET_VAL 1'b1
`define SRPS_BLOCK_RST_RESET_VAL 1'b1

`endif

// ---- logic/srps_pkg.sv ----
// Types shared by the sequencer and its lock timer.
// Assumes srps_map.svh supplies the numeric constants.
package srps_pkg;

  typedef struct packed {
    logic link_rx;
    logic pll;
    logic mipi;
  } srps_soft_release_type;

  typedef struct packed {
    logic training;
    logic video;
    logic vblank;
    logic signal_lost;
  } srps_link_status_type;

  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_TRAIN = 3'b010,
    LOCK_LOCKED = 3'b100
  } srps_lock_state_type;

  typedef enum logic [2:0] {
    MIPI_RESET = 3'b001,
    MIPI_LP11 = 3'b010,
    MIPI_HS = 3'b100
  } srps_mipi_state_type;

endpackage : srps_pkg

// ---- logic/srps_timer.sv ----
// Run-length timer: raises done once run has stayed high for LIMIT-1 cycles.
// Assumes run falls to restart the count; done is a registered level.
`timescale 1ns/1ns
`include "srps_map.svh"
module srps_timer import srps_pkg::*; #(
  parameter logic [`SRPS_TIMER_W-1:0] LIMIT = `SRPS_TIMER_W'(`SRPS_LOCK_CYCLES)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic run,
  output logic done
);

  logic [`SRPS_TIMER_W-1:0] count_reg;
  logic [`SRPS_TIMER_W-1:0] count_next;
  logic done_next;
  wire at_end = (count_reg >= LIMIT - `SRPS_TIMER_W'(2));

  // The count stops at its end so a long stall cannot wrap it back to zero.
  assign count_next = !run ? '0 : (at_end ? count_reg : count_reg + `SRPS_TIMER_W'(1));
  assign done_next = run & at_end;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      done <= 1'b0;
    end else begin
      count_reg <= count_next;
      done <= done_next;
    end
  end

endmodule : srps_timer

// ---- sim/srps_seq_monitor.sv ----
// Checker of the sequencer ports.
// Assumes it is bound into the sequencer.
`timescale 1ns/1ns
module srps_seq_monitor import srps_pkg::*; #(
  parameter int unsigned LOCK_CYCLES = 245000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Inputs
  input wire logic chip_power_down_in,
  input wire srps_soft_release_type soft_release,
  input wire logic access_req,
  input wire srps_link_status_type link_status,
  // Outputs
  input wire logic access_grant_out,
  input wire logic link_rx_rst_out,
  input wire logic pll_rst_out,
  input wire logic mipi_rst_out,
  input wire logic hot_plug_detect_out,
  input wire logic link_lock_status_out,
  input wire srps_mipi_state_type mipi_state_out,
  input wire logic mipi_first_done_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic held;
  int wait_reg;
  assign held = link_status.training && !link_status.signal_lost && chip_power_down_in
    && !link_rx_rst_out && link_lock_status_out;
  // The lock wait is too long to unroll, so a counter measures it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) wait_reg <= 0;
    else wait_reg <= held ? wait_reg + 1 : 0;
  end
  sequence s_lost; link_status.signal_lost && !link_lock_status_out; endsequence
  property p_grant; !chip_power_down_in |=> !access_grant_out; endproperty
  property p_pd; !chip_power_down_in |=> link_rx_rst_out && pll_rst_out && mipi_rst_out;
  endproperty
  property p_order; !mipi_rst_out |-> !link_rx_rst_out && !pll_rst_out; endproperty
  property p_hpd; chip_power_down_in && soft_release.link_rx |=> !hot_plug_detect_out;
  endproperty
  property p_lock; wait_reg <= int'(LOCK_CYCLES) + 3; endproperty
  property p_lost; s_lost |=> link_lock_status_out && mipi_state_out != MIPI_HS; endproperty
  property p_first; $rose(mipi_first_done_out) |-> $past(link_status.vblank)
    && mipi_state_out == MIPI_HS; endproperty
  property p_resume; mipi_first_done_out && !link_lock_status_out && link_status.video
    && !link_status.signal_lost && chip_power_down_in && &soft_release
    |=> ##[0:2] mipi_state_out == MIPI_HS; endproperty
  a_grant: assert property (p_grant) else $error("grant");
  a_pd: assert property (p_pd) else $error("reset");
  a_order: assert property (p_order) else $error("order");
  a_hpd: assert property (p_hpd) else $error("hot plug");
  a_lock: assert property (p_lock) else $error("lock");
  a_lost: assert property (p_lost) else $error("lost");
  a_first: assert property (p_first) else $error("first");
  a_resume: assert property (p_resume) else $error("resume");
endmodule : srps_seq_monitor
bind srps_sequencer srps_seq_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) i_mon (.*);

// ---- sim/srps_link_model.sv ----
// Far-end serializer: training, video with one vblank cycle a frame, loss.
// Assumes the bench steers it at the rising edge.
`timescale 1ns/1ns
module srps_link_model import srps_pkg::*; (
  // Clock
  input wire logic clock,
  // Controls
  input wire logic train,
  input wire logic video,
  input wire logic lose,
  // Link status
  output srps_link_status_type link_status
);
  logic [3:0] frame_reg = 4'h0;
  always_ff @(posedge clock) frame_reg <= frame_reg + 4'h1;
  assign link_status = {train, video, video && frame_reg == 4'h0, lose};
endmodule : srps_link_model

// ---- sim/srps_tb.sv ----
// Bench of the sequencer with the far-end model.
// Assumes the monitor is bound into the design.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb import srps_pkg::*; ;
  logic clock = 0, rstn = 0, chip_power_down_in = 0, access_req = 0;
  logic train = 0, video = 0, lose = 0, rs = 0, pd = 0, tr = 0, vd = 0, ls = 0, e;
  srps_soft_release_type soft_release = 3'h0, sr = 3'h0;
  srps_link_status_type link_status;
  logic access_grant_out, link_rx_rst_out, pll_rst_out, mipi_rst_out;
  logic hot_plug_detect_out, link_lock_status_out, mipi_first_done_out;
  srps_mipi_state_type mipi_state_out;
  logic [15:0] lf = 16'h63c7;
  logic exp_q[$];
  int fails = 0, n_compared = 0, n;
  srps_link_model i_link (.*);
  srps_sequencer #(.LOCK_CYCLES(20)) i_dut (.*);
  initial forever #2 clock = ~clock;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic step(input int k);
    repeat (k) begin
      @(posedge clock);
      lf = lfsr(lf);
      rstn <= rs;
      chip_power_down_in <= pd;
      soft_release <= sr;
      {train, video, lose} <= {tr, vd, ls};
      access_req <= lf[0];
      exp_q.push_back(lf[0] & pd);
      #1;
    end
  endtask : step
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic wait_for(input logic hs, input int lim);
    n = 0;
    while ((hs ? mipi_state_out !== MIPI_HS : link_lock_status_out !== 1'b0) && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      fails++;
      wrap_up();
    end
  endtask : wait_for
  always @(negedge clock) if (exp_q.size() > 1) begin
    e = exp_q.pop_front();
    `CHK(access_grant_out, e)
  end
  initial begin
    step(20);
    rs = 1;
    step(2);
    `CHK({link_rx_rst_out, pll_rst_out, mipi_rst_out, hot_plug_detect_out}, 4'hf)
    `CHK(mipi_state_out, MIPI_RESET)
    $display("reset test done");
    step(250);
    pd = 1;
    sr = 3'h1;
    step(80);
    `CHK({link_rx_rst_out, pll_rst_out, mipi_rst_out}, 3'h7)
    sr = 3'h6;
    step(3);
    `CHK({link_rx_rst_out, pll_rst_out, mipi_rst_out, hot_plug_detect_out}, 4'h2)
    sr = 3'h7;
    step(3);
    `CHK(mipi_state_out, MIPI_LP11)
    $display("release test done");
    tr = 1;
    wait_for(0, 26);
    `CHK(link_lock_status_out, 1'b0)
    vd = 1;
    wait_for(1, 40);
    `CHK(mipi_first_done_out, 1'b1)
    $display("lock test done");
    ls = 1;
    vd = 0;
    step(2);
    `CHK({link_lock_status_out, mipi_state_out}, {1'b1, MIPI_LP11})
    ls = 0;
    wait_for(0, 28);
    vd = 1;
    wait_for(1, 4);
    `CHK(mipi_state_out, MIPI_HS)
    $display("relock test done");
    pd = 0;
    step(2);
    `CHK({mipi_rst_out, hot_plug_detect_out, link_lock_status_out, mipi_first_done_out}, 4'he)
    $display("power down test done");
    wrap_up();
  end
endmodule : tb
